//--- verilog/pmtr_regs.vh
// Constants for the program memory table read block
`ifndef PMTR_REGS_VH
`define PMTR_REGS_VH
`define PMTR_AW 13
`define PMTR_DW 16
`define PMTR_RESET_VEC 13'h0000
`define PMTR_LAST_PAGE 5'h1f
`define PMTR_PTR_ONE 13'h0001
`define PMTR_LO_ONE 8'h01
// Instruction cycle phases T1..T4
`define PMTR_PH_T1 2'h0
`define PMTR_PH_T2 2'h1
`define PMTR_PH_T3 2'h2
`define PMTR_PH_T4 2'h3
// Table read variants: bit 0 increment, bit 1 last page
`define PMTR_K_INC 0
`define PMTR_K_LAST 1
// Serial programming frame: direction bit, 13 address bits, 16 data bits
`define PMTR_ICP_ADDR_END 6'd13
`define PMTR_ICP_DATA_END 6'd29
`define PMTR_ICP_CNT_ZERO 6'd0
`define PMTR_ICP_CNT_ONE 6'd1
// Read pulse, array address, then one clock of array latency
`define PMTR_ICP_RD_LAT 2'd3
`endif

//--- verilog/pmtr_icp.v
// Serial programming port: one data pin, clock from the programmer
`timescale 1ns/1ps
`include "pmtr_regs.vh"
module pmtr_icp #(
  parameter AW = `PMTR_AW,
  parameter DW = `PMTR_DW
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Pins from the programmer
  input wire prog_enable_pin,
  input wire prog_serial_clock,
  input wire prog_serial_data_i,
  output reg prog_serial_data_o_r,
  output reg prog_serial_data_oe_r,
  // Memory side
  output reg icp_active_r,
  output reg [AW-1:0] icp_addr_r,
  output reg [DW-1:0] icp_wdata_r,
  output reg icp_wr_r,
  output reg icp_rd_r,
  input wire [DW-1:0] pm_rdata
);
  reg [1:0] en_s_r;
  reg [1:0] ck_s_r;
  reg [1:0] da_s_r;
  reg ck_d_r;
  reg dir_rd_r;
  reg [5:0] cnt_r;
  reg [DW-1:0] sh_r;
  reg [1:0] lat_r;
  wire ck_rise;
  wire ck_fall;
  wire [5:0] cnt_inc;

  assign ck_rise = ck_s_r[1] & ~ck_d_r;
  assign ck_fall = ~ck_s_r[1] & ck_d_r;
  assign cnt_inc = cnt_r + `PMTR_ICP_CNT_ONE;

  // Pins pass two flops; only the second stage is read
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_s_r <= 2'h0;
      ck_s_r <= 2'h0;
      da_s_r <= 2'h0;
      ck_d_r <= 1'b0;
    end else begin
      en_s_r <= {en_s_r[0], prog_enable_pin};
      ck_s_r <= {ck_s_r[0], prog_serial_clock};
      da_s_r <= {da_s_r[0], prog_serial_data_i};
      ck_d_r <= ck_s_r[1];
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      icp_active_r <= 1'b0;
      icp_addr_r <= `PMTR_RESET_VEC;
      icp_wdata_r <= {DW{1'b0}};
      icp_wr_r <= 1'b0;
      icp_rd_r <= 1'b0;
      dir_rd_r <= 1'b0;
      cnt_r <= `PMTR_ICP_CNT_ZERO;
      sh_r <= {DW{1'b0}};
      lat_r <= 2'h0;
      prog_serial_data_o_r <= 1'b0;
      prog_serial_data_oe_r <= 1'b0;
    end else begin
      icp_active_r <= en_s_r[1];
      icp_wr_r <= 1'b0;
      icp_rd_r <= 1'b0;
      if (!en_s_r[1]) begin
        // Frame ends with the enable; clock may stop anywhere
        cnt_r <= `PMTR_ICP_CNT_ZERO;
        lat_r <= 2'h0;
        prog_serial_data_oe_r <= 1'b0;
      end else begin
        if (lat_r != 2'h0) begin
          lat_r <= lat_r - 2'h1;
          if (lat_r == 2'h1)
            sh_r <= pm_rdata;
        end
        // Read frames stop counting only after the last address bit is in
        if (ck_rise && !(dir_rd_r && cnt_r > `PMTR_ICP_ADDR_END)) begin
          cnt_r <= cnt_inc;
          if (cnt_r == `PMTR_ICP_CNT_ZERO) begin
            dir_rd_r <= da_s_r[1];
          end else if (cnt_r <= `PMTR_ICP_ADDR_END) begin
            icp_addr_r <= {icp_addr_r[AW-2:0], da_s_r[1]};
            if (cnt_r == `PMTR_ICP_ADDR_END && dir_rd_r) begin
              icp_rd_r <= 1'b1;
              lat_r <= `PMTR_ICP_RD_LAT;
            end
          end else begin
            sh_r <= {sh_r[DW-2:0], da_s_r[1]};
            if (cnt_r == `PMTR_ICP_DATA_END) begin
              icp_wdata_r <= {sh_r[DW-2:0], da_s_r[1]};
              icp_wr_r <= 1'b1;
              cnt_r <= `PMTR_ICP_CNT_ZERO;
            end
          end
        end
        // Pin turns round only once the programmer has sent all address bits
        if (ck_fall && dir_rd_r && cnt_r > `PMTR_ICP_ADDR_END) begin
          prog_serial_data_oe_r <= 1'b1;
          prog_serial_data_o_r <= sh_r[DW-1];
          sh_r <= {sh_r[DW-2:0], 1'b0};
        end
      end
    end
  end
endmodule

//--- verilog/pmtr_top.v
// Program memory fetch and table read engine with serial programming port
`timescale 1ns/1ps
`include "pmtr_regs.vh"
module pmtr_top #(
  parameter AW = `PMTR_AW,
  parameter DW = `PMTR_DW,
  parameter DADDR_W = 10
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Program counter control from the core
  input wire pc_load,
  input wire [AW-1:0] pc_value,
  output reg [AW-1:0] pc_r,
  output reg [DW-1:0] instr_r,
  output reg instr_valid_r,
  output reg [1:0] phase_r,
  // Table pointer writes from the core
  input wire tblp_wr,
  input wire tbhp_wr,
  input wire [7:0] tp_wdata,
  output reg [7:0] tblp_r,
  output reg [7:0] tbhp_r,
  // Table high latch software access
  input wire table_high_latch_wr,
  input wire [7:0] table_high_latch_wdata,
  output reg [7:0] table_high_latch_r,
  // Table read request
  input wire tr_req,
  input wire [1:0] tr_kind,
  input wire tr_ext,
  input wire [DADDR_W-1:0] tr_dest,
  output reg tr_busy_r,
  output reg tr_done_r,
  output reg tr_bad_op_r,
  // Data memory write of the low byte
  output reg dm_wr_r,
  output reg [DADDR_W-1:0] dm_addr_r,
  output reg [7:0] dm_wdata_r,
  // Program memory array port, one clock read latency
  output reg [AW-1:0] pm_addr_r,
  output reg [DW-1:0] pm_wdata_r,
  output reg pm_wr_r,
  input wire [DW-1:0] pm_rdata,
  // Serial programming pins
  input wire prog_enable_pin,
  input wire prog_serial_clock,
  input wire prog_serial_data_i,
  output wire prog_serial_data_o,
  output wire prog_serial_data_oe,
  output reg prog_active_r
);
  localparam S_IDLE = 2'h0;
  localparam S_CYC1 = 2'h1;
  localparam S_CYC2 = 2'h2;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [1:0] kind_r;
  reg [DADDR_W-1:0] dest_r;
  reg [AW-1:0] taddr_r;
  wire icp_active;
  wire [AW-1:0] icp_addr;
  wire [DW-1:0] icp_wdata;
  wire icp_wr;
  wire icp_rd;
  wire req_ok;
  wire sector_zero;
  wire [AW-1:0] ptr_next;

  // Pointer pair as one word address; spare high pointer bits dropped
  function [AW-1:0] tbl_addr;
    input [7:0] hi;
    input [7:0] lo;
    input last;
    begin
      if (last)
        tbl_addr = {`PMTR_LAST_PAGE, lo};
      else
        tbl_addr = {hi[AW-9:0], lo};
    end
  endfunction

  // Upper byte of a word, zero filled when the word is narrower than 16
  function [7:0] high_byte;
    input [DW-1:0] w;
    reg [15:0] wide;
    begin
      wide = 16'h0000;
      wide[DW-1:0] = w;
      high_byte = wide[15:8];
    end
  endfunction

  assign sector_zero = (tr_dest[DADDR_W-1:8] == {(DADDR_W-8){1'b0}});
  // Standard opcode only for sector zero, extended only elsewhere
  assign req_ok = (tr_ext == !sector_zero);
  // Increment variant advances the pointer before reading; last page stays in page
  assign ptr_next = tr_kind[`PMTR_K_LAST] ?
    {tbhp_r[AW-9:0], tblp_r + `PMTR_LO_ONE} :
    tbl_addr(tbhp_r, tblp_r, 1'b0) + `PMTR_PTR_ONE;

  pmtr_icp #(
    .AW(AW),
    .DW(DW)
  ) u_icp (
    .clk(clk),
    .nrst(nrst),
    .prog_enable_pin(prog_enable_pin),
    .prog_serial_clock(prog_serial_clock),
    .prog_serial_data_i(prog_serial_data_i),
    .prog_serial_data_o_r(prog_serial_data_o),
    .prog_serial_data_oe_r(prog_serial_data_oe),
    .icp_active_r(icp_active),
    .icp_addr_r(icp_addr),
    .icp_wdata_r(icp_wdata),
    .icp_wr_r(icp_wr),
    .icp_rd_r(icp_rd),
    .pm_rdata(pm_rdata)
  );

  // Four phase instruction cycle generator
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      phase_r <= `PMTR_PH_T1;
    else
      phase_r <= phase_r + 2'h1;
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (tr_req && req_ok && !icp_active && phase_r == `PMTR_PH_T4)
          state_nxt = S_CYC1;
      end
      S_CYC1: begin
        if (phase_r == `PMTR_PH_T4)
          state_nxt = S_CYC2;
      end
      S_CYC2: begin
        if (phase_r == `PMTR_PH_T4)
          state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= S_IDLE;
      kind_r <= 2'h0;
      dest_r <= {DADDR_W{1'b0}};
      taddr_r <= `PMTR_RESET_VEC;
      tblp_r <= 8'h00;
      tbhp_r <= 8'h00;
      tr_busy_r <= 1'b0;
      tr_done_r <= 1'b0;
      tr_bad_op_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tr_busy_r <= (state_nxt != S_IDLE);
      tr_done_r <= (state_r == S_CYC2) && (state_nxt == S_IDLE);
      tr_bad_op_r <= (state_r == S_IDLE) && tr_req && !req_ok &&
        (phase_r == `PMTR_PH_T4);
      if (state_r == S_IDLE && state_nxt == S_CYC1) begin
        kind_r <= tr_kind;
        dest_r <= tr_dest;
        if (tr_kind[`PMTR_K_INC]) begin
          tblp_r <= ptr_next[7:0];
          if (!tr_kind[`PMTR_K_LAST])
            tbhp_r <= {{(16-AW){1'b0}}, ptr_next[AW-1:8]};
          taddr_r <= tbl_addr({{(16-AW){1'b0}}, ptr_next[AW-1:8]}, ptr_next[7:0],
            tr_kind[`PMTR_K_LAST]);
        end else begin
          taddr_r <= tbl_addr(tbhp_r, tblp_r, tr_kind[`PMTR_K_LAST]);
        end
      end else begin
        // Core writes land in every cycle except the one that takes a table read
        if (tblp_wr)
          tblp_r <= tp_wdata;
        if (tbhp_wr)
          tbhp_r <= tp_wdata;
      end
    end
  end

  // Program counter: reset vector, step each instruction cycle, held while programming and in the first table read cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc_r <= `PMTR_RESET_VEC;
    end else if (!icp_active && phase_r == `PMTR_PH_T4) begin
      if (pc_load)
        pc_r <= pc_value;
      else if (state_nxt != S_CYC2)
        pc_r <= pc_r + `PMTR_PTR_ONE;
    end
  end

  // Memory port: programming first, then table slot, else fetch
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pm_addr_r <= `PMTR_RESET_VEC;
      pm_wdata_r <= {DW{1'b0}};
      pm_wr_r <= 1'b0;
      prog_active_r <= 1'b0;
    end else begin
      prog_active_r <= icp_active;
      pm_wr_r <= icp_wr;
      pm_wdata_r <= icp_wdata;
      if (icp_wr || icp_rd)
        pm_addr_r <= icp_addr;
      else if (!icp_active && phase_r == `PMTR_PH_T1)
        pm_addr_r <= (state_r == S_CYC2) ? taddr_r : pc_r;
    end
  end

  // Fetch capture and table data return at T3 of the owning cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      instr_r <= {DW{1'b0}};
      instr_valid_r <= 1'b0;
      dm_wr_r <= 1'b0;
      dm_addr_r <= {DADDR_W{1'b0}};
      dm_wdata_r <= 8'h00;
      table_high_latch_r <= 8'h00;
    end else begin
      instr_valid_r <= 1'b0;
      dm_wr_r <= 1'b0;
      if (!icp_active && phase_r == `PMTR_PH_T3) begin
        if (state_r == S_CYC2) begin
          dm_wr_r <= 1'b1;
          dm_addr_r <= dest_r;
          dm_wdata_r <= pm_rdata[7:0];
          table_high_latch_r <= high_byte(pm_rdata);
        end else begin
          instr_r <= pm_rdata;
          instr_valid_r <= 1'b1;
          // Fetch slot must not swallow a software write
          if (table_high_latch_wr)
            table_high_latch_r <= table_high_latch_wdata;
        end
      end else if (table_high_latch_wr) begin
        // Save and restore path around interrupt code
        table_high_latch_r <= table_high_latch_wdata;
      end
    end
  end
endmodule

//--- bench/pmtr_mem_model.sv
// Program memory array model with one clock read latency
`timescale 1ns/1ps
module pmtr_mem_model (
  // Clock
  input wire clk,
  // Array port
  input wire [12:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  output reg [15:0] rdata
);
  reg [15:0] mem [0:8191];
  integer i;
  initial begin
    for (i = 0; i < 8192; i = i + 1) begin
      mem[i] = {~i[7:0], i[7:0] ^ {3'h0, i[12:8]}};
    end
    rdata = 16'h0000;
  end
  always @(posedge clk) begin
    if (wr) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

//--- bench/pmtr_chk_sva.sv
// Assertions on the table read engine ports
`timescale 1ns/1ps
module pmtr_chk_sva #(
  parameter AW = 13,
  parameter DW = 16
) (
  input wire clk,
  input wire nrst,
  input wire [1:0] phase_r,
  input wire [AW-1:0] pc_r,
  input wire [AW-1:0] pm_addr_r,
  input wire [DW-1:0] pm_rdata,
  input wire [DW-1:0] instr_r,
  input wire instr_valid_r,
  input wire tr_busy_r,
  input wire tr_done_r,
  input wire tr_bad_op_r,
  input wire dm_wr_r,
  input wire [7:0] dm_wdata_r,
  input wire [7:0] table_high_latch_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_busy8;
    tr_busy_r [*8] ##1 !tr_busy_r;
  endsequence
  sequence s_end;
    tr_busy_r ##1 (!tr_busy_r && tr_done_r) ##1 !tr_done_r;
  endsequence
  a_busy_len: assert property ($rose(tr_busy_r) |-> s_busy8)
    else $error("busy length wrong");
  a_low_end: assert property (dm_wr_r |-> s_end)
    else $error("low byte write or done out of place");
  a_data_match: assert property (dm_wr_r |-> {table_high_latch_r, dm_wdata_r} == $past(pm_rdata))
    else $error("table data does not match array word");
  a_take_t4: assert property ($rose(tr_busy_r) |-> $past(phase_r) == 2'h3)
    else $error("table read taken off the last phase");
  a_phase_step: assert property ($past(nrst) |-> phase_r == $past(phase_r) + 2'h1)
    else $error("phase did not step");
  a_fetch_data: assert property (instr_valid_r |->
    phase_r == 2'h3 && instr_r == $past(pm_rdata) ##1 !instr_valid_r)
    else $error("fetched word wrong or late");
  a_bad_op: assert property (tr_bad_op_r |-> phase_r == 2'h0 && !tr_busy_r)
    else $error("opcode mismatch flag misplaced");
  a_reset_vec: assert property (!$past(nrst) |-> pc_r == {AW{1'b0}} && pm_addr_r == {AW{1'b0}})
    else $error("fetch does not start at word zero");
endmodule
bind pmtr_top pmtr_chk_sva #(.AW(AW), .DW(DW)) u_chk (.clk(clk), .nrst(nrst), .phase_r(phase_r),
  .pc_r(pc_r), .pm_addr_r(pm_addr_r), .pm_rdata(pm_rdata), .instr_r(instr_r),
  .instr_valid_r(instr_valid_r), .tr_busy_r(tr_busy_r), .tr_done_r(tr_done_r),
  .tr_bad_op_r(tr_bad_op_r), .dm_wr_r(dm_wr_r), .dm_wdata_r(dm_wdata_r),
  .table_high_latch_r(table_high_latch_r));

//--- bench/program_memory_table_read_tb.sv
// Self-checking bench for the table read engine
`timescale 1ns/1ps
module program_memory_table_read_tb;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg tblp_wr = 1'b0, tbhp_wr = 1'b0, lat_wr = 1'b0, tr_req = 1'b0, tr_ext = 1'b0;
  reg [7:0] tp_wdata = 8'h00, lat_wdata = 8'h00;
  reg [1:0] tr_kind = 2'h0;
  reg [9:0] tr_dest = 10'h000;
  wire [12:0] pc_r, pm_addr_r;
  wire [15:0] instr_r, pm_wdata_r, pm_rdata;
  wire [7:0] tblp_r, tbhp_r, lat_r, dm_wdata_r;
  wire [9:0] dm_addr_r;
  wire [1:0] phase_r;
  wire instr_valid_r, tr_busy_r, tr_done_r, tr_bad_op_r, dm_wr_r, pm_wr_r;
  reg icp_en = 1'b0, icp_ck = 1'b0, icp_di = 1'b0;
  wire icp_do, icp_oe, prog_active_r;
  integer bad_count = 0, comparisons = 0, cyc = 0;
  always #4 clk = ~clk;
  pmtr_top u_dut (.clk(clk), .nrst(nrst), .pc_load(1'b0), .pc_value(13'h0000), .pc_r(pc_r),
    .instr_r(instr_r), .instr_valid_r(instr_valid_r), .phase_r(phase_r), .tblp_wr(tblp_wr),
    .tbhp_wr(tbhp_wr), .tp_wdata(tp_wdata), .tblp_r(tblp_r), .tbhp_r(tbhp_r),
    .table_high_latch_wr(lat_wr), .table_high_latch_wdata(lat_wdata),
    .table_high_latch_r(lat_r), .tr_req(tr_req), .tr_kind(tr_kind), .tr_ext(tr_ext),
    .tr_dest(tr_dest), .tr_busy_r(tr_busy_r), .tr_done_r(tr_done_r),
    .tr_bad_op_r(tr_bad_op_r), .dm_wr_r(dm_wr_r), .dm_addr_r(dm_addr_r),
    .dm_wdata_r(dm_wdata_r), .pm_addr_r(pm_addr_r), .pm_wdata_r(pm_wdata_r),
    .pm_wr_r(pm_wr_r), .pm_rdata(pm_rdata), .prog_enable_pin(icp_en),
    .prog_serial_clock(icp_ck), .prog_serial_data_i(icp_di), .prog_serial_data_o(icp_do),
    .prog_serial_data_oe(icp_oe), .prog_active_r(prog_active_r));
  pmtr_mem_model u_mem (.clk(clk), .addr(pm_addr_r), .wdata(pm_wdata_r), .wr(pm_wr_r),
    .rdata(pm_rdata));
  function [15:0] memw(input [12:0] a);
    memw = {~a[7:0], a[7:0] ^ {3'h0, a[12:8]}};
  endfunction
  task chk(input string name, input [15:0] seen, input [15:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task close_out;
    $display("Mismatches %0d of %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Shared data bus, so high then low in turn
  task set_ptr(input [7:0] hi, input [7:0] lo);
    @(posedge clk);
    tbhp_wr <= 1'b1;
    tp_wdata <= hi;
    @(posedge clk);
    tbhp_wr <= 1'b0;
    tblp_wr <= 1'b1;
    tp_wdata <= lo;
    @(posedge clk);
    tblp_wr <= 1'b0;
  endtask
  task tread(input [1:0] kind, input ext, input [9:0] dest, input [12:0] a);
    integer n, nw;
    reg [15:0] w;
    begin
      w = memw(a);
      nw = 0;
      n = 0;
      @(posedge clk);
      tr_req <= 1'b1;
      tr_kind <= kind;
      tr_ext <= ext;
      tr_dest <= dest;
      while (tr_busy_r !== 1'b1 && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      tr_req <= 1'b0;
      n = 1;
      while (tr_done_r !== 1'b1 && n < 20) begin
        @(posedge clk);
        n = n + 1;
        if (dm_wr_r === 1'b1) begin
          nw = nw + 1;
          chk("dest", dm_addr_r, dest);
          chk("low byte", dm_wdata_r, w[7:0]);
          chk("high latch", lat_r, w[15:8]);
        end
      end
      chk("writes", nw, 1);
      // Done pulse ends two four-phase cycles after take, seen one edge later
      chk("cycles", n, 9);
    end
  endtask
  task t_reset_vec;
    integer n;
    begin
      n = 0;
      while (instr_valid_r !== 1'b1 && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      chk("first fetch", instr_r, memw(13'h0000));
    end
  endtask
  task t_plain;
    set_ptr(8'h1f, 8'h06);
    tread(2'h0, 1'b0, 10'h023, 13'h1f06);
  endtask
  task t_high_ignore;
    set_ptr(8'he5, 8'h34);
    tread(2'h0, 1'b0, 10'h0ff, 13'h0534);
  endtask
  task t_last_page;
    set_ptr(8'h03, 8'h7a);
    tread(2'h2, 1'b1, 10'h1c5, 13'h1f7a);
  endtask
  // Increment carries into the high pointer
  task t_inc;
    set_ptr(8'h02, 8'hff);
    tread(2'h1, 1'b1, 10'h3ff, 13'h0300);
    chk("high ptr", tbhp_r, 8'h03);
    chk("low ptr", tblp_r, 8'h00);
  endtask
  // Last page increment wraps the low pointer only
  task t_inc_last;
    set_ptr(8'h04, 8'hff);
    tread(2'h3, 1'b1, 10'h200, 13'h1f00);
    chk("high ptr", tbhp_r, 8'h04);
  endtask
  task t_bad_op(input ext, input [9:0] dest);
    integer n, nb, ny;
    begin
      nb = 0;
      ny = 0;
      @(posedge clk);
      tr_req <= 1'b1;
      tr_ext <= ext;
      tr_dest <= dest;
      for (n = 0; n < 6; n = n + 1) begin
        @(posedge clk);
        nb = nb + (tr_bad_op_r === 1'b1);
        ny = ny + (tr_busy_r === 1'b1);
      end
      tr_req <= 1'b0;
      chk("refused busy", ny, 0);
      chk("refused flag", nb > 0, 1);
    end
  endtask
  task lat_write(input [7:0] v);
    @(posedge clk);
    lat_wr <= 1'b1;
    lat_wdata <= v;
    @(posedge clk);
    lat_wr <= 1'b0;
    @(posedge clk);
  endtask
  // Software saves the latch around an interrupt-style table read
  task t_latch_sw;
    reg [7:0] saved;
    begin
      lat_write(8'h9c);
      chk("latch write", lat_r, 8'h9c);
      saved = lat_r;
      tread(2'h0, 1'b0, 10'h010, 13'h0534);
      lat_write(saved);
      chk("latch restore", lat_r, 8'h9c);
    end
  endtask
  // Programmer side: data set a clock after the fall, clock low between bits
  task icp_bit(input b);
    begin
      @(posedge clk);
      icp_di <= b;
      repeat (6) @(posedge clk);
      icp_ck <= 1'b1;
      repeat (6) @(posedge clk);
      icp_ck <= 1'b0;
    end
  endtask
  // Serial write of one word, then serial read of it back
  task t_icp;
    integer i;
    reg [12:0] a;
    reg [15:0] d, r;
    begin
      a = 13'h0abc;
      d = 16'ha5c3;
      r = 16'h0000;
      @(posedge clk);
      icp_en <= 1'b1;
      repeat (6) @(posedge clk);
      chk("prog active", prog_active_r, 1'b1);
      icp_bit(1'b0);
      for (i = 12; i >= 0; i = i - 1)
        icp_bit(a[i]);
      for (i = 15; i >= 0; i = i - 1)
        icp_bit(d[i]);
      icp_bit(1'b1);
      for (i = 12; i >= 0; i = i - 1)
        icp_bit(a[i]);
      for (i = 15; i >= 0; i = i - 1) begin
        repeat (5) @(posedge clk);
        r[i] = icp_do;
        if (i > 0) begin
          icp_ck <= 1'b1;
          repeat (6) @(posedge clk);
          icp_ck <= 1'b0;
        end
      end
      chk("prog drive", icp_oe, 1'b1);
      chk("prog read", r, d);
      icp_en <= 1'b0;
      repeat (6) @(posedge clk);
      chk("prog release", icp_oe, 1'b0);
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      bad_count = bad_count + 1;
      close_out;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset_vec;
    t_plain;
    t_high_ignore;
    t_latch_sw;
    t_last_page;
    t_inc;
    t_inc_last;
    t_bad_op(1'b0, 10'h2aa);
    t_bad_op(1'b1, 10'h011);
    t_icp;
    close_out;
  end
endmodule
